// *** verilog/lpeg_guard.sv ***
// Behaviour
// R1: configuring a mode only stores it; nothing enters low power then.
// R2: an activated mode halts the cpu; other clocks may keep running.
// R3: cpu disables interrupts, sets wake source, flushes writes, then waits.
// R4: the wait instruction re-enables interrupts while entering low power.
// R5: software calls the optional hook before wait, skipping a null hook.
// R6: small variant: return clock switching needs sub-clock as system clock.
// R7: large variant: return clock switching needs system or sub-clock.
// R8: middle speed after sleep rejects fast oscillator as return clock.
// R9: middle speed 2 after sleep rejects main clock as return clock.
// R10: middle speed with main return clock needs in-limit clock settings.
// R11: fast oscillator return clock must be powered on.
// R12: all-module stop needs module stop settings suited to that mode.
// R13: all-module stop refused during flash program or erase.
// R14: deep sleep needs the dma/transfer module stop bit set to 1.
// R15: deep sleep refused during flash program or erase.
// R16: software standby refused while oscillation stop detection is on.
// R17: software standby needs the dma run flag at 0.
// R18: software standby needs the transfer controller run flag at 0.
// R19: software standby refused during flash program or erase.
// R20: snooze variants skip the transfer run check when snooze uses it.
// R21: all checks pass: enter and report success; else cpu runs, error kept.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module lpeg_guard #(
    parameter bit LARGE_VARIANT = 1'b0,
    parameter bit HAS_SNOOZE = 1'b0,
    parameter logic [31:0] ALL_STOP_MASK = 32'hffff_ffff
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wait_exec,
    input wire logic wake_event,
    input wire logic fast_osc_on,
    input wire logic main_clk_in_limit,
    input wire logic flash_pe_mode,
    input wire logic osc_stop_detect_en,
    input wire logic dma_run_flag,
    input wire logic transfer_ctrl_run_flag,
    output logic cpu_halt,
    output logic irq_enable,
    output logic entry_done
);
    typedef enum logic [1:0] {
        LPEG_RUN = 2'b00,
        LPEG_LOW = 2'b01
    } lpeg_state_e;

    lpeg_state_e state_reg, state_next;
    logic [1:0] mode_reg;
    logic [7:0] sleep_cfg_reg;
    logic [31:0] module_stop_control_a;
    logic [2:0] err_reg;
    logic [2:0] chk_err;
    logic entered_reg;

    // apb decode: no wait states, pready rises in every access cycle
    wire wr_en = psel && penable && pwrite;
    wire hit_mode = paddr == lpeg_pkg::OFF_MODE;
    wire hit_cfg = paddr == lpeg_pkg::OFF_SLEEP_CFG;
    wire hit_mstp = paddr == lpeg_pkg::OFF_MODULE_STOP;
    wire hit_stat = paddr == lpeg_pkg::OFF_STATUS;
    wire hit_act = paddr == lpeg_pkg::OFF_ACTIVATE;
    wire mapped = hit_mode || hit_cfg || hit_mstp || hit_stat || hit_act;
    wire [31:0] rd_mux = hit_mode ? {30'h0, mode_reg} :
                         hit_cfg ? {24'h0, sleep_cfg_reg} :
                         hit_mstp ? module_stop_control_a :
                         hit_stat ? {27'h0, entered_reg, state_reg == LPEG_LOW, err_reg} : 32'h0;

    wire rsw_en = sleep_cfg_reg[lpeg_pkg::SC_RSW_EN];
    wire [1:0] rclk = sleep_cfg_reg[lpeg_pkg::SC_RCLK_LO +: 2];
    wire [1:0] opm = sleep_cfg_reg[lpeg_pkg::SC_OPM_LO +: 2];
    wire [1:0] sysclk = sleep_cfg_reg[lpeg_pkg::SC_SYS_LO +: 2];
    wire snooze_transfer = HAS_SNOOZE && sleep_cfg_reg[lpeg_pkg::SC_SNOOZE_TRANSFER];
    wire sys_ok = LARGE_VARIANT ? (sysclk == lpeg_pkg::SYS_SUB || sysclk == lpeg_pkg::SYS_PLL)
                                : (sysclk == lpeg_pkg::SYS_SUB);
    wire mstp_ok = (module_stop_control_a & ALL_STOP_MASK) == ALL_STOP_MASK;
    wire mstp_dma = module_stop_control_a[lpeg_pkg::MSTP_DMA_BIT];

    // field positions must sit inside the registers that hold them
    if (lpeg_pkg::SC_SNOOZE_TRANSFER > 7 || lpeg_pkg::MSTP_DMA_BIT > 31) begin : g_field_check
        $error("sleep config or module stop field out of range");
    end

    // entry checks, first failure in table order wins
    always_comb begin
        chk_err = lpeg_pkg::ERR_NONE;
        unique case (mode_reg)
            lpeg_pkg::MODE_SLEEP: begin
                if (rsw_en && !sys_ok) begin
                    chk_err = lpeg_pkg::ERR_BAD_CLOCK_SOURCE; // R6 R7
                end else if (rsw_en && opm == lpeg_pkg::OPM_MIDDLE && rclk == lpeg_pkg::RCLK_FAST_OSC) begin
                    chk_err = lpeg_pkg::ERR_BAD_CLOCK_SOURCE; // R8
                end else if (rsw_en && opm == lpeg_pkg::OPM_MIDDLE2 && rclk == lpeg_pkg::RCLK_MAIN) begin
                    chk_err = lpeg_pkg::ERR_BAD_CLOCK_SOURCE; // R9
                end else if (rsw_en && opm == lpeg_pkg::OPM_MIDDLE && rclk == lpeg_pkg::RCLK_MAIN
                             && !main_clk_in_limit) begin
                    chk_err = lpeg_pkg::ERR_BAD_MAIN_CLOCK_FREQ; // R10
                end else if (rsw_en && rclk == lpeg_pkg::RCLK_FAST_OSC && !fast_osc_on) begin
                    chk_err = lpeg_pkg::ERR_BAD_CLOCK_SOURCE; // R11
                end
            end
            lpeg_pkg::MODE_ALL_STOP: begin
                if (!mstp_ok || flash_pe_mode) begin
                    chk_err = lpeg_pkg::ERR_ILLEGAL_STATE; // R12 R13
                end
            end
            lpeg_pkg::MODE_DEEP_SLEEP: begin
                if (!mstp_dma) begin
                    chk_err = lpeg_pkg::ERR_DEEP_SLEEP_STATUS; // R14
                end else if (flash_pe_mode) begin
                    chk_err = lpeg_pkg::ERR_ILLEGAL_STATE; // R15
                end
            end
            lpeg_pkg::MODE_SW_STANDBY: begin
                if (osc_stop_detect_en) begin
                    chk_err = lpeg_pkg::ERR_OSC_STOP_DETECT_ON; // R16
                end else if (dma_run_flag || (transfer_ctrl_run_flag && !snooze_transfer) || flash_pe_mode) begin
                    chk_err = lpeg_pkg::ERR_ILLEGAL_STATE; // R17 R18 R19 R20
                end
            end
        endcase
    end

    // a wait request while running either enters low power or records the error
    wire wait_req = wait_exec || (wr_en && hit_act && pwdata[0]);
    wire enter = state_reg == LPEG_RUN && wait_req && chk_err == lpeg_pkg::ERR_NONE; // R21

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LPEG_RUN: if (enter) state_next = LPEG_LOW; // R2
            LPEG_LOW: if (wake_event) state_next = LPEG_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= LPEG_RUN;
            mode_reg <= lpeg_pkg::MODE_SLEEP;
            sleep_cfg_reg <= 8'h00;
            module_stop_control_a <= lpeg_pkg::MSTP_RESET;
            err_reg <= lpeg_pkg::ERR_NONE;
            entered_reg <= 1'b0;
            cpu_halt <= 1'b0;
            irq_enable <= 1'b1;
            entry_done <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state_reg <= state_next;
            // mode write only records the choice
            if (wr_en && hit_mode) mode_reg <= pwdata[1:0]; // R1
            if (wr_en && hit_cfg) sleep_cfg_reg <= pwdata[7:0];
            if (wr_en && hit_mstp) module_stop_control_a <= pwdata;
            if (state_reg == LPEG_RUN && wait_req) begin
                err_reg <= chk_err; // R21
                entered_reg <= enter;
            end
            cpu_halt <= state_next == LPEG_LOW; // R2
            // interrupts are on while halted so the wake source can end the mode
            irq_enable <= (state_next == LPEG_LOW) || (!(wait_req && state_reg == LPEG_RUN) && irq_enable); // R4
            entry_done <= state_reg == LPEG_RUN && wait_req;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
        end
    end

    property p_halt_after_enter;
        @(posedge mclk) disable iff (srst)
        enter |=> cpu_halt && irq_enable;
    endproperty
    a_halt_after_enter: assert property (p_halt_after_enter) // R2
        else $error("entry did not halt the cpu");

    property p_refused_keeps_running;
        @(posedge mclk) disable iff (srst)
        state_reg == LPEG_RUN && wait_req && chk_err != lpeg_pkg::ERR_NONE
        |=> !cpu_halt && err_reg != lpeg_pkg::ERR_NONE;
    endproperty
    a_refused_keeps_running: assert property (p_refused_keeps_running) // R21
        else $error("refused entry halted the cpu");

    property p_mode_write_no_entry;
        @(posedge mclk) disable iff (srst)
        wr_en && hit_mode && !wait_exec && !cpu_halt |=> !cpu_halt;
    endproperty
    a_mode_write_no_entry: assert property (p_mode_write_no_entry) // R1
        else $error("mode write entered low power");

    property p_deep_sleep_stop_bit;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_DEEP_SLEEP |-> mstp_dma && !flash_pe_mode;
    endproperty
    a_deep_sleep_stop_bit: assert property (p_deep_sleep_stop_bit) // R14
        else $error("deep sleep entered with bad state");

    property p_standby_osc;
        @(posedge mclk) disable iff (srst)
        state_reg == LPEG_RUN && wait_req && mode_reg == lpeg_pkg::MODE_SW_STANDBY && osc_stop_detect_en
        |=> err_reg == lpeg_pkg::ERR_OSC_STOP_DETECT_ON;
    endproperty
    a_standby_osc: assert property (p_standby_osc) // R16
        else $error("standby osc check missed");

    property p_standby_dma;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_SW_STANDBY |-> !dma_run_flag && !flash_pe_mode;
    endproperty
    a_standby_dma: assert property (p_standby_dma) // R17
        else $error("standby entered with dma or flash busy");

    property p_allstop_flash;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_ALL_STOP |-> !flash_pe_mode && mstp_ok;
    endproperty
    a_allstop_flash: assert property (p_allstop_flash) // R13
        else $error("all-module stop entered illegally");

    property p_fast_osc_off;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_SLEEP && rsw_en && rclk == lpeg_pkg::RCLK_FAST_OSC
        |-> fast_osc_on;
    endproperty
    a_fast_osc_off: assert property (p_fast_osc_off) // R11
        else $error("sleep entered with fast oscillator off");

    property p_irq_on_while_halted;
        @(posedge mclk) disable iff (srst)
        cpu_halt |-> irq_enable;
    endproperty
    a_irq_on_while_halted: assert property (p_irq_on_while_halted) // R4
        else $error("halted with interrupts off");

    property p_small_sys_clock;
        @(posedge mclk) disable iff (srst)
        !LARGE_VARIANT && enter && mode_reg == lpeg_pkg::MODE_SLEEP && rsw_en
        |-> sysclk == lpeg_pkg::SYS_SUB;
    endproperty
    a_small_sys_clock: assert property (p_small_sys_clock) // R6
        else $error("small variant slept without sub-clock");

    property p_large_sys_clock;
        @(posedge mclk) disable iff (srst)
        LARGE_VARIANT && enter && mode_reg == lpeg_pkg::MODE_SLEEP && rsw_en
        |-> sysclk == lpeg_pkg::SYS_SUB || sysclk == lpeg_pkg::SYS_PLL;
    endproperty
    a_large_sys_clock: assert property (p_large_sys_clock) // R7
        else $error("large variant slept with bad system clock");

    property p_middle_no_fast_osc;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_SLEEP && rsw_en && opm == lpeg_pkg::OPM_MIDDLE
        |-> rclk != lpeg_pkg::RCLK_FAST_OSC;
    endproperty
    a_middle_no_fast_osc: assert property (p_middle_no_fast_osc) // R8
        else $error("middle speed slept with fast oscillator return");

    property p_middle2_no_main;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_SLEEP && rsw_en && opm == lpeg_pkg::OPM_MIDDLE2
        |-> rclk != lpeg_pkg::RCLK_MAIN;
    endproperty
    a_middle2_no_main: assert property (p_middle2_no_main) // R9
        else $error("middle speed 2 slept with main clock return");

    property p_main_freq_err;
        @(posedge mclk) disable iff (srst)
        state_reg == LPEG_RUN && wait_req && mode_reg == lpeg_pkg::MODE_SLEEP && rsw_en && sys_ok
        && opm == lpeg_pkg::OPM_MIDDLE && rclk == lpeg_pkg::RCLK_MAIN && !main_clk_in_limit
        |=> err_reg == lpeg_pkg::ERR_BAD_MAIN_CLOCK_FREQ;
    endproperty
    a_main_freq_err: assert property (p_main_freq_err) // R10
        else $error("main clock frequency error missed");

    property p_allstop_mask;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_ALL_STOP
        |-> (module_stop_control_a & ALL_STOP_MASK) == ALL_STOP_MASK;
    endproperty
    a_allstop_mask: assert property (p_allstop_mask) // R12
        else $error("all-module stop entered with modules running");

    property p_deep_sleep_flash;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_DEEP_SLEEP |-> !flash_pe_mode;
    endproperty
    a_deep_sleep_flash: assert property (p_deep_sleep_flash) // R15
        else $error("deep sleep entered during flash program or erase");

    property p_standby_transfer;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_SW_STANDBY && !snooze_transfer
        |-> !transfer_ctrl_run_flag;
    endproperty
    a_standby_transfer: assert property (p_standby_transfer) // R18
        else $error("standby entered with transfer controller running");

    property p_standby_flash;
        @(posedge mclk) disable iff (srst)
        enter && mode_reg == lpeg_pkg::MODE_SW_STANDBY |-> !flash_pe_mode;
    endproperty
    a_standby_flash: assert property (p_standby_flash) // R19
        else $error("standby entered during flash program or erase");

    property p_snooze_transfer_skip;
        @(posedge mclk) disable iff (srst)
        state_reg == LPEG_RUN && wait_req && mode_reg == lpeg_pkg::MODE_SW_STANDBY && snooze_transfer
        && !osc_stop_detect_en && !dma_run_flag && !flash_pe_mode |=> cpu_halt;
    endproperty
    a_snooze_transfer_skip: assert property (p_snooze_transfer_skip) // R20
        else $error("snooze transfer use blocked standby");

    property p_entry_reported;
        @(posedge mclk) disable iff (srst)
        state_reg == LPEG_RUN && wait_req |=> entry_done;
    endproperty
    a_entry_reported: assert property (p_entry_reported) // R21
        else $error("wait request not reported");
endmodule : lpeg_guard
`default_nettype wire

// *** verilog/lpeg_pkg.sv ***
package lpeg_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_SLEEP_CFG = 8'h04;
    localparam logic [7:0] OFF_MODULE_STOP = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_ACTIVATE = 8'h10;
    // low power mode codes
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_ALL_STOP = 2'h1;
    localparam logic [1:0] MODE_DEEP_SLEEP = 2'h2;
    localparam logic [1:0] MODE_SW_STANDBY = 2'h3;
    // return clock codes
    localparam logic [1:0] RCLK_LOW_OSC = 2'h0;
    localparam logic [1:0] RCLK_FAST_OSC = 2'h1;
    localparam logic [1:0] RCLK_MAIN = 2'h2;
    // system clock source codes
    localparam logic [1:0] SYS_SUB = 2'h3;
    localparam logic [1:0] SYS_PLL = 2'h2;
    // post-sleep operating modes
    localparam logic [1:0] OPM_HIGH = 2'h0;
    localparam logic [1:0] OPM_MIDDLE = 2'h1;
    localparam logic [1:0] OPM_MIDDLE2 = 2'h2;
    // sleep config fields, then the module stop dma bit
    localparam int SC_RSW_EN = 0;
    localparam int SC_RCLK_LO = 1;
    localparam int SC_OPM_LO = 3;
    localparam int SC_SYS_LO = 5;
    localparam int SC_SNOOZE_TRANSFER = 7;
    localparam int MSTP_DMA_BIT = 28;
    // error codes, then the module stop reset value
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_BAD_CLOCK_SOURCE = 3'h1;
    localparam logic [2:0] ERR_BAD_MAIN_CLOCK_FREQ = 3'h2;
    localparam logic [2:0] ERR_ILLEGAL_STATE = 3'h3;
    localparam logic [2:0] ERR_OSC_STOP_DETECT_ON = 3'h4;
    localparam logic [2:0] ERR_DEEP_SLEEP_STATUS = 3'h5;
    localparam logic [31:0] MSTP_RESET = 32'h0000_0000;
endpackage : lpeg_pkg

// *** tb/lpeg_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module lpeg_cpu_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic go,
    input wire logic slow,
    input wire logic cpu_halt,
    output logic wait_exec,
    output logic wake_event
);
    logic [3:0] cnt;
    always_ff @(posedge mclk) begin
        // go means interrupts are off, the wake source is set and the hook has run
        wait_exec <= go && !srst;
        if (srst || !cpu_halt) begin
            cnt <= 4'h0;
            wake_event <= 1'b0;
        end else begin
            cnt <= cnt + 4'h1;
            wake_event <= (cnt >= (slow ? 4'ha : 4'h1));
        end
    end
endmodule : lpeg_cpu_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic go = 1'b0, slow = 1'b0, slv, wait_exec, wake_event, cpu_halt, irq_enable;
    logic entry_done, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [5:0] sta = 6'h30;
    int n_fail = 0, num_checks = 0;
    always #4 mclk = ~mclk;
    lpeg_guard i_lpeg_guard (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wait_exec(wait_exec), .wake_event(wake_event),
        .fast_osc_on(sta[5]), .main_clk_in_limit(sta[4]), .flash_pe_mode(sta[3]),
        .osc_stop_detect_en(sta[2]), .dma_run_flag(sta[1]), .transfer_ctrl_run_flag(sta[0]),
        .cpu_halt(cpu_halt), .irq_enable(irq_enable), .entry_done(entry_done));
    lpeg_cpu_model i_lpeg_cpu_model (.mclk(mclk), .srst(srst), .go(go), .slow(slow),
        .cpu_halt(cpu_halt), .wait_exec(wait_exec), .wake_event(wake_event));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask : chk
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // leading edge keeps back-to-back calls from reassigning psel in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task run(input logic how, input logic [1:0] m, input logic [7:0] c, input logic [31:0] ms,
             input logic [5:0] s, input logic [2:0] e);
        apb(1'b1, 8'h00, {30'h0, m});
        apb(1'b1, 8'h04, {24'h0, c});
        apb(1'b1, 8'h08, ms);
        sta <= s;
        slow <= how;
        @(posedge mclk);
        chk({31'h0, cpu_halt}, 32'h0);
        if (how) apb(1'b1, 8'h10, 32'h1);
        else begin
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
        end
        do @(posedge mclk); while (entry_done !== 1'b1);
        chk({31'h0, cpu_halt}, {31'h0, e == 3'h0});
        chk({31'h0, irq_enable}, {31'h0, e == 3'h0});
        apb(1'b0, 8'h0c, 32'h0);
        chk({27'h0, r[4:0]}, {27'h0, e == 3'h0, e == 3'h0, e});
        while (cpu_halt === 1'b1) @(posedge mclk);
    endtask : run
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, slv}, 32'h1);
        chk(r, 32'h0);
        run(1'b0, 2'h0, 8'h00, 32'h0, 6'h30, 3'h0);
        run(1'b1, 2'h0, 8'h41, 32'h0, 6'h30, 3'h1);
        run(1'b0, 2'h0, 8'h6b, 32'h0, 6'h30, 3'h1);
        run(1'b0, 2'h0, 8'h75, 32'h0, 6'h30, 3'h1);
        run(1'b0, 2'h0, 8'h6d, 32'h0, 6'h20, 3'h2);
        run(1'b1, 2'h0, 8'h6d, 32'h0, 6'h30, 3'h0);
        run(1'b0, 2'h0, 8'h63, 32'h0, 6'h10, 3'h1);
        run(1'b0, 2'h1, 8'h00, 32'h0, 6'h30, 3'h3);
        run(1'b0, 2'h1, 8'h00, 32'hffff_ffff, 6'h38, 3'h3);
        run(1'b1, 2'h1, 8'h00, 32'hffff_ffff, 6'h30, 3'h0);
        run(1'b0, 2'h2, 8'h00, 32'h0, 6'h30, 3'h5);
        run(1'b0, 2'h2, 8'h00, 32'h1000_0000, 6'h38, 3'h3);
        run(1'b1, 2'h2, 8'h00, 32'h1000_0000, 6'h30, 3'h0);
        run(1'b0, 2'h3, 8'h00, 32'h0, 6'h34, 3'h4);
        run(1'b0, 2'h3, 8'h00, 32'h0, 6'h32, 3'h3);
        run(1'b0, 2'h3, 8'h00, 32'h0, 6'h31, 3'h3);
        run(1'b0, 2'h3, 8'h00, 32'h0, 6'h38, 3'h3);
        // mid-run reset while interrupts are off and standby is chosen
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chk({31'h0, cpu_halt}, 32'h0);
        chk({31'h0, irq_enable}, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h0);
        run(1'b1, 2'h3, 8'h00, 32'h0, 6'h30, 3'h0);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
